// >>> core/tml_codec.sv
/*
 * Three-channel character codec with APB registers: encoder, serializer,
 * receiver boundary search, decoder and channel alignment.
 * Assumes the serial inputs arrive one bit per CLK_SYS and the link clock
 * input is asynchronous; the pixel source follows TX_CLK_OUT.
 */
// Notes on behaviour
// - Blanking sends four control characters; active data never forms them.
// - Each channel takes pixel byte, two control bits and pixel valid.
// - Signed running disparity per channel, updated every character.
// - One 10-bit character per input set; ones and zeros counters used.
// - Characters leave least significant bit first.
// - Ten serial bits per pixel clock period.
// - Receiver locks to the link character clock quickly, well inside limit.
// - Character boundaries found from runs of blanking characters.
// - Recovered outputs hold while any channel is out of sync.
// - Channels aligned onto one strobe with transmit channel mapping.
// - Transmit pipeline stays below 64 pixel periods.
// - Receive pipeline stays below 64 pixel periods.
// - No link error detection is performed.
// - Stage one chains XOR or XNOR from bit 0; bit 8 marks which.
// - Stage two may invert low eight bits; bit 9 marks inversion.
// - Pixel valid picks pixel byte or control bits, ignoring the other.
// - Each control bit pair maps to its own blanking character.
`timescale 1ns/10ps
`default_nettype none
module tml_codec
    import tml_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [23:0] TX_PIXEL,
    input wire logic [2:0] TX_CTRL_BIT_LO,
    input wire logic [2:0] TX_CTRL_BIT_HI,
    input wire logic TX_PIXEL_VALID,
    output logic TX_CHAR_TAKEN,
    output logic [2:0] TX_SERIAL,
    output logic TX_CLK_OUT,
    input wire logic RX_CLK_IN,
    input wire logic [2:0] RX_SERIAL,
    output logic [23:0] RX_PIXEL,
    output logic [2:0] RX_CTRL_BIT_LO,
    output logic [2:0] RX_CTRL_BIT_HI,
    output logic RX_PIXEL_VALID,
    output logic RX_STROBE
);
    // Ones and zeros in a byte
    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    function automatic logic [3:0] count_zeros(input logic [7:0] v);
        return 4'h8 - count_ones(v);
    endfunction : count_zeros

    function automatic logic [9:0] ctrl_char(input logic [1:0] c);
        logic [9:0] q;
        unique case (c)
            2'h0: q = CTRL_CHAR_00;
            2'h1: q = CTRL_CHAR_01;
            2'h2: q = CTRL_CHAR_10;
            2'h3: q = CTRL_CHAR_11;
        endcase
        return q;
    endfunction : ctrl_char

    function automatic logic is_ctrl(input logic [9:0] q);
        return q == CTRL_CHAR_00 || q == CTRL_CHAR_01 || q == CTRL_CHAR_10 || q == CTRL_CHAR_11;
    endfunction : is_ctrl

    // Result {disparity, character}
    function automatic logic [14:0] encode(input logic [7:0] d, input logic [1:0] ctl, input logic de,
                                           input logic signed [4:0] cnt);
        logic [8:0] qm;
        logic xn;
        logic [3:0] n1;
        logic [3:0] n0;
        logic [9:0] q;
        logic signed [4:0] c;
        logic signed [4:0] diff;
        xn = count_ones(d) > 4'h4 || (count_ones(d) == 4'h4 && !d[0]);
        qm[0] = d[0];
        for (int i = 1; i < 8; i++)
        begin
            qm[i] = xn ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
        end
        qm[8] = ~xn;
        n1 = count_ones(qm[7:0]);
        n0 = count_zeros(qm[7:0]);
        diff = $signed({1'b0, n1}) - $signed({1'b0, n0});
        if (!de)
        begin
            q = ctrl_char(ctl);
            c = 5'sd0;
        end
        else if (cnt == 5'sd0 || n1 == n0)
        begin
            q = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
            c = qm[8] ? cnt + diff : cnt - diff;
        end
        else if ((!cnt[4] && n1 > n0) || (cnt[4] && n0 > n1))
        begin
            q = {1'b1, qm[8], ~qm[7:0]};
            c = cnt + (qm[8] ? 5'sd2 : 5'sd0) - diff;
        end
        else
        begin
            q = {1'b0, qm[8], qm[7:0]};
            c = cnt - (qm[8] ? 5'sd0 : 5'sd2) + diff;
        end
        return {c, q};
    endfunction : encode

    // Result {pixel valid, control pair, pixel byte}
    function automatic logic [10:0] decode(input logic [9:0] q);
        logic [7:0] v;
        logic [7:0] d;
        v = q[9] ? ~q[7:0] : q[7:0];
        d[0] = v[0];
        for (int i = 1; i < 8; i++)
        begin
            d[i] = q[8] ? (v[i] ^ v[i-1]) : ~(v[i] ^ v[i-1]);
        end
        if (q == CTRL_CHAR_00) return {3'h0, 8'h00};
        if (q == CTRL_CHAR_01) return {3'h1, 8'h00};
        if (q == CTRL_CHAR_10) return {3'h2, 8'h00};
        if (q == CTRL_CHAR_11) return {3'h3, 8'h00};
        return {3'h4, d};
    endfunction : decode

    logic [1:0] ctrl_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [3:0] tx_bit_q;
    logic tx_take_q;
    logic tx_clk_q;
    logic [CHAN-1:0][9:0] tx_shift_q;
    logic [CHAN-1:0][4:0] tx_disp_q;
    logic [CHAN-1:0][14:0] enc_w;
    logic [2:0] lclk_q;
    logic [7:0] gap_q;
    logic [4:0] edges_q;
    logic locked_q;
    logic [CHAN-1:0] rx_s1_q;
    logic [CHAN-1:0] rx_s2_q;
    logic [CHAN-1:0][9:0] rx_win_q;
    logic [CHAN-1:0][3:0] rx_ph_q;
    logic [CHAN-1:0][7:0] rx_run_q;
    logic [CHAN-1:0] rx_sync_q;
    logic [CHAN-1:0] rx_new_q;
    logic [CHAN-1:0][10:0] rx_word_q;
    logic [23:0] rx_pix_q;
    logic [2:0] rx_lo_q;
    logic [2:0] rx_hi_q;
    logic rx_de_q;
    logic rx_stb_q;

    // Bus decode and status word
    wire apb_access = PSEL && PENABLE && !pready_q;
    wire apb_done = PSEL && PENABLE && pready_q;
    wire hit_ctrl = PADDR == ADDR_CTRL;
    wire hit_stat = PADDR == ADDR_STATUS;
    wire all_sync = &rx_sync_q;
    wire [31:0] status_w = {27'h000_0000, all_sync, rx_sync_q, locked_q};
    wire [31:0] rd_w = hit_ctrl ? {30'h0000_0000, ctrl_q} : (hit_stat ? status_w : 32'h0000_0000);

    // APB slave, one wait state
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl_q <= CTRL_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= apb_access;
            pslverr_q <= apb_access && !hit_ctrl && !hit_stat;
            if (apb_access)
                prdata_q <= rd_w;
            if (apb_done && PWRITE && hit_ctrl)
                ctrl_q <= PWDATA[1:0];
        end
    end

    // Transmit inputs, forced to blanking 00 while disabled
    wire tx_en = ctrl_q[CTRL_TX_EN_BIT];
    wire tx_de = TX_PIXEL_VALID && tx_en;
    wire tx_load = tx_bit_q == 4'(BITS_PER_CHAR - 1);
    wire [3:0] tx_bit_d = tx_load ? 4'h0 : tx_bit_q + 4'h1;

    // Bit counter and character clock divider
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            // Start at the last bit so the first edge loads a whole character
            tx_bit_q <= 4'(BITS_PER_CHAR - 1);
            tx_take_q <= 1'b0;
            tx_clk_q <= 1'b0;
        end
        else
        begin
            tx_bit_q <= tx_bit_d;
            tx_take_q <= tx_load;
            tx_clk_q <= tx_bit_d < 4'(BITS_PER_CHAR / 2);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHAN; ch++)
        begin : g_tx
            assign enc_w[ch] = encode(TX_PIXEL[ch*8 +: 8], {TX_CTRL_BIT_HI[ch] && tx_en, TX_CTRL_BIT_LO[ch] && tx_en},
                                      tx_de, $signed(tx_disp_q[ch]));
            // Character load and shift out
            always_ff @(posedge CLK_SYS or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    tx_shift_q[ch] <= CTRL_CHAR_00;
                    tx_disp_q[ch] <= 5'h00;
                end
                else if (tx_load)
                begin
                    tx_shift_q[ch] <= enc_w[ch][9:0];
                    tx_disp_q[ch] <= enc_w[ch][14:10];
                end
                else
                    tx_shift_q[ch] <= {1'b0, tx_shift_q[ch][9:1]};
            end
            assign TX_SERIAL[ch] = tx_shift_q[ch][0];
        end
    endgenerate

    // Link clock edge finder and lock
    wire lclk_rise = lclk_q[1] && !lclk_q[2];
    wire rx_run_ok = locked_q && ctrl_q[CTRL_RX_EN_BIT];
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            lclk_q <= 3'h0;
            gap_q <= 8'h00;
            edges_q <= 5'h00;
            locked_q <= 1'b0;
        end
        else
        begin
            lclk_q <= {lclk_q[1:0], RX_CLK_IN};
            gap_q <= lclk_rise ? 8'h00 : (gap_q == CLK_GAP_MAX ? gap_q : gap_q + 8'h01);
            if (gap_q == CLK_GAP_MAX)
                edges_q <= 5'h00;
            else if (lclk_rise && edges_q != LOCK_EDGES)
                edges_q <= edges_q + 5'h01;
            locked_q <= edges_q == LOCK_EDGES && gap_q != CLK_GAP_MAX;
        end
    end

    wire consume = &rx_new_q;
    generate
        for (ch = 0; ch < CHAN; ch++)
        begin : g_rx
            wire win_ctrl = is_ctrl(rx_win_q[ch]);
            wire bound = rx_ph_q[ch] == 4'(BITS_PER_CHAR - 1);
            wire realign = !rx_sync_q[ch] && win_ctrl && !bound;
            // Boundary search, run count and decode per channel
            always_ff @(posedge CLK_SYS or negedge RST_B)
            begin
                if (!RST_B)
                begin
                    rx_s1_q[ch] <= 1'b0;
                    rx_s2_q[ch] <= 1'b0;
                    rx_win_q[ch] <= 10'h000;
                    rx_ph_q[ch] <= 4'h0;
                    rx_run_q[ch] <= 8'h00;
                    rx_sync_q[ch] <= 1'b0;
                    rx_new_q[ch] <= 1'b0;
                    rx_word_q[ch] <= 11'h000;
                end
                else
                begin
                    rx_s1_q[ch] <= RX_SERIAL[ch];
                    rx_s2_q[ch] <= rx_s1_q[ch];
                    rx_win_q[ch] <= {rx_s2_q[ch], rx_win_q[ch][9:1]};
                    rx_ph_q[ch] <= (bound || realign) ? 4'h0 : rx_ph_q[ch] + 4'h1;
                    if (!rx_run_ok)
                        rx_run_q[ch] <= 8'h00;
                    else if (bound)
                        rx_run_q[ch] <= !win_ctrl ? 8'h00 : (rx_run_q[ch] == 8'hFF ? 8'hFF : rx_run_q[ch] + 8'h01);
                    else if (realign)
                        rx_run_q[ch] <= 8'h01;
                    if (!rx_run_ok)
                        rx_sync_q[ch] <= 1'b0;
                    else if (bound && win_ctrl && rx_run_q[ch] == SYNC_RUN - 8'h01)
                        rx_sync_q[ch] <= 1'b1;
                    rx_new_q[ch] <= (bound && rx_sync_q[ch]) || (rx_new_q[ch] && !consume);
                    if (bound)
                        rx_word_q[ch] <= decode(rx_win_q[ch]);
                end
            end
        end
    endgenerate

    // Aligned output update, held while out of sync
    wire rx_upd = consume && all_sync;
    wire rx_de = rx_word_q[0][10];
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rx_pix_q <= 24'h00_0000;
            rx_lo_q <= 3'h0;
            rx_hi_q <= 3'h0;
            rx_de_q <= 1'b0;
            rx_stb_q <= 1'b0;
        end
        else
        begin
            rx_stb_q <= rx_upd;
            if (rx_upd)
            begin
                rx_de_q <= rx_de;
                if (rx_de)
                    rx_pix_q <= {rx_word_q[2][7:0], rx_word_q[1][7:0], rx_word_q[0][7:0]};
                else
                begin
                    rx_lo_q <= {rx_word_q[2][8], rx_word_q[1][8], rx_word_q[0][8]};
                    rx_hi_q <= {rx_word_q[2][9], rx_word_q[1][9], rx_word_q[0][9]};
                end
            end
        end
    end

    // Output wiring from flip-flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign TX_CHAR_TAKEN = tx_take_q;
    assign TX_CLK_OUT = tx_clk_q;
    assign RX_PIXEL = rx_pix_q;
    assign RX_CTRL_BIT_LO = rx_lo_q;
    assign RX_CTRL_BIT_HI = rx_hi_q;
    assign RX_PIXEL_VALID = rx_de_q;
    assign RX_STROBE = rx_stb_q;

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    sequence s_quiet9;
        (!tx_take_q)[*8] ##1 !tx_take_q;
    endsequence
    sequence s_lsb_pair;
        (TX_SERIAL[0] == $past(enc_w[0][0])) ##1 (TX_SERIAL[0] == $past(enc_w[0][1], 2));
    endsequence
    chk_char_period: assert property (tx_take_q |-> ##1 s_quiet9 ##1 tx_take_q)
        else $error("character period is not ten clocks");
    chk_lsb_first: assert property (tx_load |=> s_lsb_pair)
        else $error("serial order is not lsb first");
    chk_clk_period: assert property ($rose(TX_CLK_OUT) |-> ##10 $rose(TX_CLK_OUT))
        else $error("character clock period wrong");
    chk_blank_char: assert property (tx_load && !tx_de |=> is_ctrl(tx_shift_q[0]) && tx_disp_q[0] == 5'h00)
        else $error("blanking did not send a control character");
    chk_data_not_ctrl: assert property (tx_load && tx_de |=> !is_ctrl(tx_shift_q[0]))
        else $error("data formed a control character");
    chk_disp_even: assert property (tx_disp_q[1][0] == 1'b0)
        else $error("running disparity became odd");
    chk_sync_run: assert property ($rose(rx_sync_q[0]) |-> $past(rx_run_q[0]) == SYNC_RUN - 8'h01)
        else $error("sync without full blanking run");
    chk_hold_unsync: assert property (!all_sync |=> $stable(RX_PIXEL) && !RX_STROBE)
        else $error("outputs moved while out of sync");
    chk_ctrl_hold: assert property (RX_STROBE && RX_PIXEL_VALID |-> $stable(RX_CTRL_BIT_LO))
        else $error("control changed during pixel data");
    chk_apb_ready: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("bus access not answered");
endmodule : tml_codec
`default_nettype wire

// >>> core/tml_pkg.sv
/*
 * Constants for the three-channel character codec: register map, field
 * positions, reset values, control characters and timing counts.
 * Assumes a 25 MHz system clock and one serial bit per system clock.
 */
package tml_pkg;
    localparam int CHAN = 3;
    localparam int BITS_PER_CHAR = 10;
    // Blanking characters, indexed {ctrl_bit_hi, ctrl_bit_lo}
    localparam logic [9:0] CTRL_CHAR_00 = 10'h354;
    localparam logic [9:0] CTRL_CHAR_01 = 10'h0AB;
    localparam logic [9:0] CTRL_CHAR_10 = 10'h154;
    localparam logic [9:0] CTRL_CHAR_11 = 10'h2AB;
    // Register map, byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int CTRL_TX_EN_BIT = 0;
    localparam int CTRL_RX_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_SYNC_LSB = 1;
    localparam int STAT_ALL_BIT = 4;
    // Link timing, in pixel periods
    localparam int MIN_BLANK_SPAN = 128;
    localparam int TX_PIPELINE_LIMIT = 64;
    localparam int RX_PIPELINE_LIMIT = 64;
    // Boundary lock: consecutive aligned blanking characters needed
    localparam logic [7:0] SYNC_RUN = 8'h10;
    // Link clock lock: edges needed and longest gap between edges
    localparam logic [4:0] LOCK_EDGES = 5'h10;
    localparam logic [7:0] CLK_GAP_MAX = 8'h40;
endpackage : tml_pkg

// >>> bench/tml_far_end.sv
/* Far end of the link: hears the three serial lines, loops them back and
   makes the link clock. Assumes one bit per clk, framed by tx_clk_out. */
`timescale 1ns/10ps
`default_nettype none
module tml_far_end
(
    input wire logic clk,
    input wire logic run_clk,
    input wire logic [2:0] tx_serial,
    input wire logic tx_clk_out,
    output logic [2:0] rx_serial,
    output logic rx_clk_in,
    output logic [29:0] chars,
    output logic done,
    output logic [7:0] bad_frames
);
    logic prev_q = 1'b0;
    logic done_q = 1'b0;
    logic [7:0] bad_q = 8'h00;
    logic [3:0] idx_q = 4'hf;
    logic [9:0] sh_q [3];
    wire rise = tx_clk_out && !prev_q;
    wire [3:0] nxt = rise ? 4'h0 : idx_q + 4'h1;
    // Loopback: the far transmitter repeats what it hears
    assign rx_serial = tx_serial;
    assign done = done_q;
    assign bad_frames = bad_q;
    // Link clock stands still while run_clk is low
    initial
    begin
        rx_clk_in = 1'b0;
        forever #160 rx_clk_in = run_clk ? ~rx_clk_in : rx_clk_in;
    end
    // Gather bits; a frame must last exactly ten clocks
    always @(posedge clk)
    begin
        prev_q <= tx_clk_out;
        done_q <= 1'b0;
        if (idx_q != 4'hf && rise != (idx_q == 4'h9))
            bad_q <= bad_q + 8'h01;
        if (rise || idx_q != 4'hf)
        begin
            idx_q <= nxt;
            for (int c = 0; c < 3; c++)
                sh_q[c][nxt] <= tx_serial[c];
            if (nxt == 4'h9)
            begin
                done_q <= 1'b1;
                for (int c = 0; c < 3; c++)
                    chars[c*10 +: 10] <= {tx_serial[c], sh_q[c][8:0]};
            end
        end
    end
endmodule : tml_far_end
`default_nettype wire

// >>> bench/tb_top.sv
/* Bench for the codec: feeds pixels and control pairs, checks characters,
   recovered outputs and registers. Assumes the far end loops lines back. */
`timescale 1ns/10ps
`default_nettype none
module tb_top import tml_pkg::*;;
    logic clk, rst_b, psel, penable, pwrite, tx_valid, run_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, taken, tx_clk, rx_clk, rx_valid, rx_strobe, done, er;
    logic [23:0] tx_pix, rx_pix;
    logic [2:0] tx_lo, tx_hi, tx_ser, rx_ser, rx_lo, rx_hi;
    logic [29:0] chars, ech;
    logic [30:0] cur, last_set, exp_rx;
    logic [7:0] bad, v;
    int errors, checked, strobes, s0;
    int disp [3];
    logic [29:0] exp_q [$];
    logic [30:0] set_q [$];
    logic [30:0] stim_q [$];
    localparam logic [7:0] TBL [10] = '{8'h00, 8'hff, 8'h0f, 8'h1e, 8'h55, 8'haa, 8'h01, 8'hfe, 8'h80, 8'h10};
    wire [30:0] rx_all = {rx_valid, rx_hi, rx_lo, rx_pix};

    tml_codec u_dut (.CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TX_PIXEL(tx_pix), .TX_CTRL_BIT_LO(tx_lo), .TX_CTRL_BIT_HI(tx_hi), .TX_PIXEL_VALID(tx_valid),
        .TX_CHAR_TAKEN(taken), .TX_SERIAL(tx_ser), .TX_CLK_OUT(tx_clk), .RX_CLK_IN(rx_clk),
        .RX_SERIAL(rx_ser), .RX_PIXEL(rx_pix), .RX_CTRL_BIT_LO(rx_lo), .RX_CTRL_BIT_HI(rx_hi),
        .RX_PIXEL_VALID(rx_valid), .RX_STROBE(rx_strobe));
    tml_far_end u_far (.clk(clk), .run_clk(run_clk), .tx_serial(tx_ser), .tx_clk_out(tx_clk),
        .rx_serial(rx_ser), .rx_clk_in(rx_clk), .chars(chars), .done(done), .bad_frames(bad));

    // Reference encoder for one channel, keeping its own disparity
    function automatic logic [9:0] ref_enc(input logic dv, input logic [7:0] d, input logic [1:0] cp,
        input int c);
        logic [8:0] m;
        logic x;
        int dn;
        if (!dv)
        begin
            disp[c] = 0;
            return cp == 2'b00 ? 10'h354 : cp == 2'b01 ? 10'h0ab : cp == 2'b10 ? 10'h154 : 10'h2ab;
        end
        x = $countones(d) > 4 || ($countones(d) == 4 && !d[0]);
        m[0] = d[0];
        for (int i = 1; i < 8; i++)
            m[i] = m[i-1] ^ d[i] ^ x;
        m[8] = !x;
        dn = 2 * $countones(m[7:0]) - 8;
        if (disp[c] == 0 || dn == 0)
        begin
            disp[c] += m[8] ? dn : -dn;
            return {!m[8], m[8], m[8] ? m[7:0] : ~m[7:0]};
        end
        if ((disp[c] > 0) == (dn > 0))
        begin
            disp[c] += 2 * int'(m[8]) - dn;
            return {1'b1, m[8], ~m[7:0]};
        end
        disp[c] += dn - 2 * int'(!m[8]);
        return {1'b0, m[8], m[7:0]};
    endfunction : ref_enc

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic put(input logic dv, input logic [2:0] hi, input logic [2:0] lo, input int n);
        repeat (n) stim_q.push_back({dv, hi, lo, {~v, v ^ 8'h3c, v}});
    endtask : put

    task automatic drain();
        int w;
        w = 0;
        while (stim_q.size() > 0 && w < 3000)
        begin
            @(posedge clk);
            w++;
        end
        repeat (30) @(posedge clk);
    endtask : drain

    // Pixel run with ignored control bits held high
    task automatic sends(input logic [7:0] k);
        for (int i = 0; i < 40; i++)
        begin
            v = i < 10 ? TBL[i] : 8'(i * 37) + k;
            put(1'b1, 3'b111, 3'b111, 1);
        end
        drain();
    endtask : sends

    task automatic status(input logic [31:0] exp);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
        check(rd, exp, "status");
    endtask : status

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Driver: next input set at each taken pulse, with its expectation
    always @(posedge clk)
    begin
        if (taken === 1'b1)
        begin
            if (stim_q.size() > 0)
                cur = stim_q.pop_front();
            tx_valid <= cur[30];
            tx_hi <= cur[29:27];
            tx_lo <= cur[26:24];
            tx_pix <= cur[23:0];
            for (int c = 0; c < 3; c++)
                ech[c*10 +: 10] = ref_enc(cur[30], cur[c*8 +: 8], {cur[27+c], cur[24+c]}, c);
            exp_q.push_back(ech);
            set_q.push_back(cur);
        end
    end

    // Monitor: characters on the wire and recovered outputs
    always @(posedge clk)
    begin
        if (done === 1'b1 && exp_q.size() > 0)
        begin
            check(32'(chars), 32'(exp_q.pop_front()), "char");
            last_set = set_q.pop_front();
        end
        if (rx_strobe === 1'b1)
        begin
            strobes++;
            if (last_set[30])
                exp_rx[23:0] = last_set[23:0];
            else
                exp_rx[29:24] = last_set[29:24];
            exp_rx[30] = last_set[30];
            check(32'(rx_all), 32'(exp_rx), "rx out");
        end
    end

    initial
    begin
        repeat (12000) @(posedge clk);
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial
    begin
        {rst_b, psel, penable, pwrite, tx_valid, run_clk} = 6'b000001;
        paddr = 12'h000;
        pwdata = 32'h0;
        {tx_pix, tx_lo, tx_hi, v} = 38'h0;
        {cur, last_set, exp_rx} = 93'h0;
        exp_q.push_back({3{10'h354}});
        set_q.push_back(31'h0);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
        check(rd, 32'h0000_0003, "ctrl reset");
        apb(1'b0, 12'h008, 32'h0, rd, er);
        check({rd[30:0], er}, 32'h0000_0001, "unmapped");
        put(1'b0, 3'b100, 3'b010, 5);
        drain();
        check(32'(strobes), 32'h0, "early strobe");
        check(32'(rx_all), 32'h0, "early out");
        $display("test reset and registers done");
        // Long blanking, then pixels
        put(1'b0, 3'b100, 3'b010, 140);
        drain();
        status(32'h0000_001f);
        apb(1'b1, ADDR_STATUS, 32'h0, rd, er);
        status(32'h0000_001f);
        s0 = strobes;
        sends(8'h05);
        check(32'(strobes - s0 >= 40), 32'h1, "strobes");
        $display("test sync and pixels done");
        // Link clock stops: sync drops, outputs hold
        run_clk <= 1'b0;
        repeat (100) @(posedge clk);
        status(32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001, rd, er);
        apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
        check(rd, 32'h0000_0001, "ctrl write");
        apb(1'b1, ADDR_CTRL, 32'h0000_0003, rd, er);
        s0 = strobes;
        sends(8'h21);
        check(32'(strobes - s0), 32'h0, "held strobe");
        check(32'(rx_all), 32'(exp_rx), "held out");
        run_clk <= 1'b1;
        put(1'b0, 3'b110, 3'b101, 140);
        drain();
        status(32'h0000_001f);
        s0 = strobes;
        sends(8'h47);
        check(32'(strobes - s0 >= 40), 32'h1, "strobes");
        check(32'(bad), 32'h0, "framing");
        $display("test lock loss done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
